//--- rtl/timer_clock_control.sv
/*
 holds: clock select, prescaler, run control, gate
   flip-flop and a 16-bit counter behind a plain port
 assumes: pins are asynchronous to MCLK; RST_N is the
   power-on/brown-out reset, WARM_RST_N any other reset
*/
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "timer_clock_defs.svh"
// How it works
// R1: code 01 system clock, 00 quarter clock
// R2: software never uses source code 11
// R3: code 10, oscillator off: pin rising edges
// R4: code 10, oscillator on: crystal clock
// R5: prescale codes divide by 1,2,4,8
// R6: bit 3 switches secondary oscillator
// R7: code 1X: bit 2 clear synchronises
// R8: code 0X ignores the sync bit
// R9: bit 1 picks 16-bit or 8-bit access
// R10: bit 0 runs or stops the timer
// R11: clearing run clears gate flip-flop
// R12: full reset zeroes; warm reset clears bit 1
// R13: low byte read buffers the high byte
// R14: counter advances per prescaler tick
module timer_clock_control
   import timer_clock_pkg::*;
(
   input  wire logic       MCLK,
   input  wire logic       RST_N,
   input  wire logic       WARM_RST_N,
   input  wire logic [3:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       EXT_COUNT_CLOCK_PIN,
   input  wire logic       CRYSTAL_IN_PIN,
   output logic            CRYSTAL_OUT_PIN,
   output logic            OSC_ENABLE,
   input  wire logic       GATE_EVENT,
   output logic            GATE_STATE
);

   // ------------------------------------------------
   // reset release
   // ------------------------------------------------
   logic       rst_meta_reg;   // first release stage
   logic       rst_sync_reg;   // released reset copy
   logic       rst_n;          // used everywhere

   // release through two flops, assert at once
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   assign rst_n = rst_sync_reg;

   // ------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------
   logic [`PIN_LANES-1:0] pin_raw;       // pin lanes
   logic [`PIN_LANES-1:0] pin_meta_reg;  // stage one
   logic [`PIN_LANES-1:0] pin_sync_reg;  // stage two
   logic [`PIN_LANES-1:0] pin_prev_reg;  // edge history

   // lane 0 warm reset, 1 pin clock, 2 crystal, 3 gate
   assign pin_raw = {GATE_EVENT, CRYSTAL_IN_PIN,
                     EXT_COUNT_CLOCK_PIN, WARM_RST_N};

   // one two-flop synchroniser per lane
   genvar gi;
   generate
      for (gi = 0; gi < `PIN_LANES; gi = gi + 1)
      begin : g_sync
         always_ff @(posedge MCLK or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pin_meta_reg[gi] <= 1'b0;
               pin_sync_reg[gi] <= 1'b0;
               pin_prev_reg[gi] <= 1'b0;
            end
            else
            begin
               pin_meta_reg[gi] <= pin_raw[gi];
               pin_sync_reg[gi] <= pin_meta_reg[gi];
               pin_prev_reg[gi] <= pin_sync_reg[gi];
            end
         end
      end
   endgenerate

   logic warm_rst;    // other reset, active
   logic ext_rise;    // pin clock rising edge
   logic xtal_rise;   // crystal rising edge
   logic gate_rise;   // gate event rising edge

   // edge detectors compare the second stage with its history flop
   assign warm_rst  = ~pin_sync_reg[0];
   assign ext_rise  = pin_sync_reg[1] & ~pin_prev_reg[1];
   assign xtal_rise = pin_sync_reg[2] & ~pin_prev_reg[2];
   assign gate_rise = pin_sync_reg[3] & ~pin_prev_reg[3];

   // ------------------------------------------------
   // control register
   // ------------------------------------------------
   logic [7:0] ctrl_reg;    // control bits
   logic [7:0] ctrl_next;   // next control bits
   count_src_e src;         // count clock select
   logic [1:0] ps_sel;      // prescale select
   logic       osc_en;      // secondary osc enable
   logic       sync_bypass; // skip extra sync stage
   logic       wide_en;     // 16-bit access enable
   logic       run;         // timer run

   // software write, then warm reset clears bit 1
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (WR && (ADDR == `CTRL_ADDR))
      begin
         ctrl_next = WDATA;
      end
      if (warm_rst)
      begin
         ctrl_next[`WIDE_BIT] = 1'b0;   // [R12]
      end
   end

   // full reset zeroes every control bit
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg <= `CTRL_RST;   // [R12]
      end
      else
      begin
         ctrl_reg <= ctrl_next;
      end
   end

   // field views
   assign src         = count_src_e'(ctrl_reg[`CS_HI:`CS_LO]);
   assign ps_sel      = ctrl_reg[`PS_HI:`PS_LO];
   assign osc_en      = ctrl_reg[`OSC_BIT];
   assign sync_bypass = ctrl_reg[`SYNC_BIT];
   assign wide_en     = ctrl_reg[`WIDE_BIT];
   assign run         = ctrl_reg[`RUN_BIT];

   // ------------------------------------------------
   // count clock selection
   // ------------------------------------------------
   logic [1:0] div_reg;        // quarter clock divider
   logic [1:0] div_next;
   logic       edge_dly_reg;   // synchronised pin edge
   logic       edge_dly_next;
   logic       xtal_out_reg;   // oscillator drive
   logic       xtal_out_next;
   logic       pin_edge;       // chosen pin edge
   logic       instr_tick;     // quarter clock tick
   logic       src_tick;       // selected clock tick

   // pick the tick of the selected source
   always_comb
   begin
      div_next      = div_reg + 2'h1;
      instr_tick    = (div_reg == `INSTR_DIV_TOP);
      // crystal or pin clock by oscillator enable
      pin_edge      = osc_en ? xtal_rise : ext_rise;   // [R3] [R4]
      // extra stage aligns the edge to MCLK
      edge_dly_next = pin_edge;
      // inverter drive only while oscillator on
      xtal_out_next = osc_en & ~pin_sync_reg[2];   // [R6]
      case (src)
         SRC_INSTR:
         begin
            src_tick = instr_tick;   // [R1]
         end
         SRC_SYS:
         begin
            src_tick = 1'b1;   // [R1] [R8]
         end
         SRC_PIN:
         begin
            // bit 2 only matters here
            src_tick = sync_bypass ? pin_edge
                                   : edge_dly_reg;   // [R7]
         end
         default:
         begin
            // reserved code gives no ticks
            src_tick = 1'b0;   // [R2]
         end
      endcase
   end

   // register the clock selection state
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_reg      <= 2'h0;
         edge_dly_reg <= 1'b0;
         xtal_out_reg <= 1'b0;
      end
      else
      begin
         div_reg      <= div_next;
         edge_dly_reg <= edge_dly_next;
         xtal_out_reg <= xtal_out_next;
      end
   end

   // ------------------------------------------------
   // prescaler
   // ------------------------------------------------
   presc_t presc_reg;    // prescaler position
   presc_t presc_next;
   presc_t presc_mask;   // bits that must be full
   logic   presc_tick;   // prescaled tick

   // divide selected clock by 1, 2, 4 or 8
   always_comb
   begin
      case (ps_sel)
         2'h0:    presc_mask = 3'h0;   // [R5]
         2'h1:    presc_mask = 3'h1;   // [R5]
         2'h2:    presc_mask = 3'h3;   // [R5]
         default: presc_mask = 3'h7;   // [R5]
      endcase
      presc_tick = src_tick &&
                   ((presc_reg & presc_mask) == presc_mask);
      presc_next = presc_reg;
      if (!run)
      begin
         presc_next = 3'h0;   // [R10]
      end
      else if (presc_tick)
      begin
         presc_next = 3'h0;
      end
      else if (src_tick)
      begin
         presc_next = presc_reg + 3'h1;
      end
   end

   // register the prescaler
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         presc_reg <= 3'h0;
      end
      else
      begin
         presc_reg <= presc_next;
      end
   end

   // ------------------------------------------------
   // counter, gate and register port
   // ------------------------------------------------
   logic [15:0] cnt_reg;      // timer value
   logic [15:0] cnt_next;
   logic [7:0]  hi_buf_reg;   // high byte buffer
   logic [7:0]  hi_buf_next;
   logic [7:0]  rdata_reg;    // read data
   logic [7:0]  rdata_next;
   logic        gate_reg;     // gate flip-flop
   logic        gate_next;

   // counting, buffered access and readback
   always_comb
   begin
      cnt_next    = cnt_reg;
      hi_buf_next = hi_buf_reg;
      rdata_next  = 8'h00;
      if (run && presc_tick)
      begin
         cnt_next = cnt_reg + 16'h0001;   // [R14] [R10]
      end
      // software write wins over a count
      if (WR && (ADDR == `CNT_LO_ADDR))
      begin
         if (wide_en)
         begin
            cnt_next = {hi_buf_reg, WDATA};   // [R9]
         end
         else
         begin
            cnt_next[7:0] = WDATA;   // [R9]
         end
      end
      if (WR && (ADDR == `CNT_HI_ADDR))
      begin
         if (wide_en)
         begin
            hi_buf_next = WDATA;   // [R9]
         end
         else
         begin
            cnt_next[15:8] = WDATA;   // [R9]
         end
      end
      if (RD)
      begin
         case (ADDR)
            `CTRL_ADDR:
            begin
               rdata_next = ctrl_reg;
            end
            `CNT_LO_ADDR:
            begin
               rdata_next = cnt_reg[7:0];
               if (wide_en)
               begin
                  hi_buf_next = cnt_reg[15:8];   // [R13]
               end
            end
            `CNT_HI_ADDR:
            begin
               rdata_next = wide_en ? hi_buf_reg
                                    : cnt_reg[15:8];   // [R9]
            end
            default:
            begin
               rdata_next = 8'h00;   // unmapped
            end
         endcase
      end
      // gate toggles on events, cleared when stopped
      gate_next = gate_reg;
      if (!run)
      begin
         gate_next = 1'b0;   // [R11]
      end
      else if (gate_rise)
      begin
         gate_next = ~gate_reg;
      end
   end

   // register counter, buffer, read data, gate
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg    <= `CNT_RST;
         hi_buf_reg <= 8'h00;
         rdata_reg  <= 8'h00;
         gate_reg   <= 1'b0;
      end
      else
      begin
         cnt_reg    <= cnt_next;
         hi_buf_reg <= hi_buf_next;
         rdata_reg  <= rdata_next;
         gate_reg   <= gate_next;
      end
   end

   // ------------------------------------------------
   // outputs
   // ------------------------------------------------
   assign RDATA           = rdata_reg;
   assign CRYSTAL_OUT_PIN = xtal_out_reg;
   assign OSC_ENABLE      = ctrl_reg[`OSC_BIT];   // [R6]
   assign GATE_STATE      = gate_reg;

endmodule
`default_nettype wire

//--- rtl/timer_clock_defs.svh
/*
 holds: offsets, field positions, reset values and counts
 assumes: included by bare name from rtl/
*/
`ifndef TIMER_CLOCK_DEFS_SVH
`define TIMER_CLOCK_DEFS_SVH
// register offsets on the plain port
`define CTRL_ADDR     4'h0
`define CNT_LO_ADDR   4'h1
`define CNT_HI_ADDR   4'h2
// control field positions
`define CS_HI         7
`define CS_LO         6
`define PS_HI         5
`define PS_LO         4
`define OSC_BIT       3
`define SYNC_BIT      2
`define WIDE_BIT      1
`define RUN_BIT       0
// reset values
`define CTRL_RST      8'h00
`define CNT_RST       16'h0000
// instruction clock is a quarter of the system clock
`define INSTR_DIV_TOP 2'h3
// pin synchroniser lanes
`define PIN_LANES     4
`endif

//--- rtl/timer_clock_pkg.sv
/*
 holds: types shared by the timer clock control
 assumes: compiled before the design module
*/
package timer_clock_pkg;
   // count clock source codes, in field order 00..11
   typedef enum logic [1:0] {
      SRC_INSTR,
      SRC_SYS,
      SRC_PIN,
      SRC_RESERVED
   } count_src_e;
   // prescaler position
   typedef logic [2:0] presc_t;
endpackage

//--- tb/ext_clock_model.sv
/*
 holds: model of the external clock pin and the crystal input
 assumes: bursts are started one at a time by the bench
*/
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// burst source, both lines idle low
// ----------------------------------------
module ext_clock_model
#(
   parameter int EDGES = 5,  // rising edges per burst
   parameter int HALF  = 40  // half period in ns, above two system cycles
)
(
   input  wire logic go,       // burst start
   input  wire logic use_xtal, // burst on the crystal input
   output logic      pin,      // external count clock
   output logic      xtal,     // crystal input
   output logic      done      // burst finished
);
   initial
   begin
      pin = 1'b0;
      xtal = 1'b0;
      done = 1'b1;
   end
   // one square wave burst per request
   always @(posedge go)
   begin
      done = 1'b0;
      // offset keeps every pin change clear of a system clock edge
      #3;
      repeat (EDGES)
      begin
         #HALF;
         if (use_xtal)
            xtal = 1'b1;
         else
            pin = 1'b1;
         #HALF;
         pin = 1'b0;
         xtal = 1'b0;
      end
      done = 1'b1;
   end
endmodule
`default_nettype wire

//--- tb/testbench.sv
/*
 holds: self-checking bench for the timer clock control
 assumes: design, package, checker and clock model compiled first
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_clock_defs.svh"
// ----------------------------------------
// bench top
// ----------------------------------------
module testbench;
   import timer_clock_pkg::*;
   logic       MCLK, RST_N, WARM_RST_N, WR, RD, GATE_EVENT;
   logic [3:0] ADDR;
   logic [7:0] WDATA, RDATA, lo, hi, l2, h2;
   logic       pin, xtal, done, go, ux, pend, sb;
   logic [7:0] exp_q [$];  // expected read data in order
   int         miscompares, num_checks, d;
   logic [3:0] pc [6] = '{4'b0001, 4'b0101, 4'b1111, 4'b1011, 4'b0010, 4'b1000};
   timer_clock_control i_dut (.MCLK(MCLK), .RST_N(RST_N), .WARM_RST_N(WARM_RST_N), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_COUNT_CLOCK_PIN(pin),
      .CRYSTAL_IN_PIN(xtal), .CRYSTAL_OUT_PIN(), .OSC_ENABLE(), .GATE_EVENT(GATE_EVENT),
      .GATE_STATE());
   ext_clock_model i_src (.go(go), .use_xtal(ux), .pin(pin), .xtal(xtal), .done(done));
   initial
   begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one bus cycle, strobes held until the next call
   task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] v);
      WR <= w;
      RD <= r;
      ADDR <= a;
      WDATA <= v;
      @(posedge MCLK);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      bus(1'b1, 1'b0, a, v);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, 1'b1, a, 8'h00);
   endtask
   task automatic idle(input int n);
      WR <= 1'b0;
      RD <= 1'b0;
      repeat (n) @(posedge MCLK);
   endtask
   // read data stand in the cycle after the strobe
   always @(posedge MCLK) pend <= RD;
   always @(negedge MCLK)
      if (pend && exp_q.size() > 0)
         chk("rdata", RDATA, exp_q.pop_front());
   initial
   begin
      {RST_N, WR, RD, GATE_EVENT, go, ux, ADDR, WDATA} = '0;
      WARM_RST_N = 1'b1;
      void'($urandom(32'hc9502e3f));
      // all scenarios; a hang leaves this block for the closing report
      begin : scen
      repeat (4) @(posedge MCLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge MCLK);
      for (int a = 3; a < 16; a++)
      begin
         wr(4'(a), 8'($urandom));
         rd(4'(a), 8'h00);
      end
      rd(`CTRL_ADDR, 8'h00);
      // internal sources and every prescale code, sync bit random
      for (int s = 0; s < 2; s++) // codes 00 and 01 only, reserved 11 never written
         for (int p = 0; p < 4; p++)
         begin
            lo = 8'($urandom_range(200));
            hi = 8'($urandom);
            sb = 1'($urandom);
            d = (s == 0 ? 12 : 3) << p;
            wr(`CNT_LO_ADDR, lo);
            wr(`CNT_HI_ADDR, hi);
            wr(`CTRL_ADDR, {s[1:0], p[1:0], 1'b0, sb, 2'b01});
            idle(d - 1);
            wr(`CTRL_ADDR, {s[1:0], p[1:0], 1'b0, sb, 2'b00});
            rd(`CNT_LO_ADDR, lo + 8'h03);
            rd(`CNT_HI_ADDR, hi);
         end
      // pin and crystal sources
      foreach (pc[i])
      begin
         wr(`CNT_LO_ADDR, 8'h00);
         wr(`CTRL_ADDR, {4'b1000, pc[i][3], pc[i][2], 2'b01});
         idle(4);
         ux <= pc[i][1];
         go <= 1'b1;
         idle(1);
         go <= 1'b0;
         for (int t = 0; t < 200 && !done; t++) @(posedge MCLK);
         if (!done)
         begin
            miscompares++;
            disable scen;
         end
         idle(8);
         wr(`CTRL_ADDR, {4'b1000, pc[i][3], pc[i][2], 2'b00});
         rd(`CNT_LO_ADDR, pc[i][0] ? 8'h05 : 8'h00);
      end
      // byte and wide access
      {lo, hi, l2, h2} = 32'($urandom);
      wr(`CTRL_ADDR, 8'h00);
      wr(`CNT_LO_ADDR, lo);
      wr(`CNT_HI_ADDR, hi);
      wr(`CTRL_ADDR, 8'h02);
      wr(`CNT_HI_ADDR, ~hi);
      wr(`CTRL_ADDR, 8'h00);
      rd(`CNT_HI_ADDR, hi);
      wr(`CTRL_ADDR, 8'h02);
      rd(`CNT_LO_ADDR, lo);
      rd(`CNT_HI_ADDR, hi);
      wr(`CNT_HI_ADDR, h2);
      wr(`CNT_LO_ADDR, l2);
      wr(`CTRL_ADDR, 8'h00);
      rd(`CNT_LO_ADDR, l2);
      rd(`CNT_HI_ADDR, h2);
      // gate flip-flop toggles while running, clears on stop
      wr(`CTRL_ADDR, 8'h01);
      idle(2);
      GATE_EVENT <= 1'b1;
      idle(6);
      chk("gate", {7'h00, i_dut.GATE_STATE}, 8'h01);
      GATE_EVENT <= 1'b0;
      wr(`CTRL_ADDR, 8'h00);
      idle(3);
      chk("gate", {7'h00, i_dut.GATE_STATE}, 8'h00);
      // other reset clears only the wide bit
      wr(`CTRL_ADDR, 8'hbe);
      idle(1);
      WARM_RST_N <= 1'b0;
      idle(3);
      WARM_RST_N <= 1'b1;
      idle(4);
      rd(`CTRL_ADDR, 8'hbc);
      idle(1);
      RST_N <= 1'b0;
      idle(4);
      RST_N <= 1'b1;
      idle(3);
      rd(`CTRL_ADDR, 8'h00);
      idle(3);
      end
      end_of_test();
   end
endmodule
`default_nettype wire

//--- tb/timer_clock_control_chk.sv
/*
 holds: port checker for the timer clock control
 assumes: bound to timer_clock_control, defs header on the include path
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_clock_defs.svh"
// ----------------------------------------
// checker
// ----------------------------------------
module timer_clock_control_chk
(
   input wire logic       MCLK,
   input wire logic       RST_N,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic       CRYSTAL_OUT_PIN,
   input wire logic       OSC_ENABLE,
   input wire logic       GATE_STATE
);
   logic       cw;     // control write taken
   logic [7:0] sh_reg; // shadow of the control register
   assign cw = WR && ADDR == `CTRL_ADDR;
   // shadow follows software writes only
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         sh_reg <= 8'h00;
      else if (cw)
         sh_reg <= WDATA;
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   AST_RST: assert property ($rose(RST_N) |-> !OSC_ENABLE && !GATE_STATE)
      else $error("outputs not cleared by reset");
   AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data outside its cycle");
   AST_RD_UNMAP: assert property (RD && ADDR > `CNT_HI_ADDR |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
   AST_RD_CTRL: assert property (RD && ADDR == `CTRL_ADDR |=> {RDATA[7:2], RDATA[0]} == {sh_reg[7:2], sh_reg[0]})
      else $error("control readback differs");
   AST_OSC_CHG: assert property ($changed(OSC_ENABLE) |-> $past(cw) || $past(cw, 2))
      else $error("oscillator enable moved without a write");
   AST_OSC_FOLLOW: assert property (cw ##1 (!cw) [*2] |-> ##1 OSC_ENABLE == $past(WDATA[3], 3))
      else $error("oscillator enable does not follow bit 3");
   AST_XOUT_OFF: assert property (!OSC_ENABLE && !$past(OSC_ENABLE) |-> !CRYSTAL_OUT_PIN)
      else $error("crystal drive while oscillator off");
   AST_GATE_CLR: assert property (cw && !WDATA[0] |-> ##2 !GATE_STATE)
      else $error("gate flip-flop not cleared on stop");
endmodule
bind timer_clock_control timer_clock_control_chk i_chk (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CRYSTAL_OUT_PIN(CRYSTAL_OUT_PIN),
   .OSC_ENABLE(OSC_ENABLE), .GATE_STATE(GATE_STATE));
`default_nettype wire
